// File: pds_params.svh
// Constants for the pre-trigger delay scheduler
`ifndef PDS_PARAMS_SVH
`define PDS_PARAMS_SVH

`define PDS_CNT_W        16
`define PDS_NUM_PT       2
`define PDS_NUM_SRC      64
`define PDS_SRC_SEL_W    6
`define PDS_NUM_TGT      8
`define PDS_NUM_SLOT     4
`define PDS_SLOT_W       8
`define PDS_ROUTE_W      32
`define PDS_TGT_DELAY    3'h0
`define PDS_PRESC_W      3
`define PDS_PRE_CNT_W    8
`define PDS_PRE_ONE      8'h01
`define PDS_LD_IMM       2'h0
`define PDS_LD_MOD       2'h1
`define PDS_LD_TRIG      2'h2
`define PDS_LD_EITHER    2'h3
`define PDS_CNT_RST      16'h0000
`define PDS_CNT_ONE      16'h0001
`define PDS_MOD_RST      16'hffff
`define PDS_DLY_RST      16'h0000

`endif

// File: pds_pkg.sv
// Types shared by the pre-trigger delay scheduler modules
`include "pds_params.svh"

package pds_pkg;
   // One routing control word: four source selections, slot 0 is the first
   typedef logic [`PDS_NUM_SLOT-1:0][`PDS_SLOT_W-1:0] pds_route_t;

   typedef logic [1:0] pds_ld_mode_t;

   typedef struct packed {
      logic                    en;
      logic                    cont;
      pds_ld_mode_t            ld_mode;
      logic [`PDS_PRESC_W-1:0] prescale;
      logic [1:0]              trig_sel;
      logic                    err_irq_en;
   } pds_ctrl_t;

   typedef struct packed {
      logic en;
      logic back_to_back;
   } pds_pt_cfg_t;
endpackage

// File: pds_router.sv
// Trigger routing matrix: one control word per target, four selections each
`timescale 1ns/1ps
`default_nettype none
`include "pds_params.svh"

module pds_router (
   input  wire logic                                     clk_sys,
   input  wire logic                                     nrst,
   input  wire logic [`PDS_NUM_SRC-1:0]                  trig_src,
   input  wire pds_pkg::pds_route_t [`PDS_NUM_TGT-1:0]   route_ctrl,
   output logic [`PDS_NUM_TGT-1:0][`PDS_NUM_SLOT-1:0]    routed_q
);
   import pds_pkg::*;

   genvar t, s;
   generate
      for (t = 0; t < `PDS_NUM_TGT; t++) begin : g_tgt
         for (s = 0; s < `PDS_NUM_SLOT; s++) begin : g_slot
            // Upper bits of each field are reserved and ignored
            always_ff @(posedge clk_sys) begin
               if (!nrst) begin
                  routed_q[t][s] <= 1'b0; // see R1
               end else begin
                  routed_q[t][s] <= trig_src[route_ctrl[t][s][`PDS_SRC_SEL_W-1:0]]; // see R2
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// File: pds_scheduler.sv
// Pre-trigger delay scheduler: routing, delay counter, buffered delays, locks
`timescale 1ns/1ps
`default_nettype none
`include "pds_params.svh"

// Operation
// R1 - Each target owns a 32-bit routing word
// R2 - Four independent source selections per word
// R3 - Software routes timer trigger to slot 0
// R4 - Software routes triggers to outputs 2,3,6
// R5 - Software picks sensorless or Hall timer trigger
// R6 - 16-bit counter restarts on input trigger
// R7 - Pre-triggers fire in programmed delay order
// R8 - Every pre-trigger has its own delay
// R9 - Counter ticks on shared timer clock
// R10 - Software sets current pre-trigger delay zero
// R11 - Software sets dynamic delays from duty
// R12 - Software clamps dynamic delay 180 to 1800
// R13 - Sequence error flag with optional interrupt
// R14 - Buffered delays load after load-ok plus trigger
// R15 - Prescaler, source, load mode, pre-trigger mode configurable
// R16 - Software sets modulo to half PWM cycle
// R17 - Channel locked until conversion complete
// R18 - Single-clock pulse on delay match
// R19 - Error when firing into a held lock
module pds_scheduler (
   input  wire logic                                     clk_sys,
   input  wire logic                                     nrst,
   input  wire logic [`PDS_NUM_SRC-1:0]                  trig_src,
   input  wire pds_pkg::pds_route_t [`PDS_NUM_TGT-1:0]   route_ctrl,
   input  wire pds_pkg::pds_ctrl_t                       scheduler_control,
   input  wire pds_pkg::pds_pt_cfg_t [`PDS_NUM_PT-1:0]   pt_cfg,
   input  wire logic                                     load_ok,
   input  wire logic                                     mod_we,
   input  wire logic [`PDS_CNT_W-1:0]                    mod_wdata,
   input  wire logic [`PDS_NUM_PT-1:0]                   dly_we,
   input  wire logic [`PDS_CNT_W-1:0]                    dly_wdata,
   input  wire logic [`PDS_NUM_PT-1:0]                   conversion_complete,
   input  wire logic                                     err_clr,
   output logic [`PDS_NUM_TGT-1:0][`PDS_NUM_SLOT-1:0]    routed_trig,
   output logic [`PDS_NUM_PT-1:0]                        pretrig,
   output logic [`PDS_NUM_PT-1:0]                        pretrig_lock,
   output logic                                          seq_err,
   output logic                                          seq_err_irq,
   output logic                                          load_pending,
   output logic                                          running,
   output logic [`PDS_CNT_W-1:0]                         count
);
   import pds_pkg::*;

   logic [`PDS_NUM_TGT-1:0][`PDS_NUM_SLOT-1:0] routed_q;
   logic                        trig_d_q;
   logic                        trig_in;
   logic                        trig_evt;
   logic                        running_q;
   logic [`PDS_CNT_W-1:0]       cnt_q;
   logic [`PDS_PRE_CNT_W-1:0]   pre_cnt_q;
   logic [`PDS_PRE_CNT_W-1:0]   presc_lim;
   logic                        tick;
   logic                        mod_hit;
   logic [`PDS_CNT_W-1:0]       mod_buf_q;
   logic [`PDS_CNT_W-1:0]       mod_act_q;
   logic [`PDS_CNT_W-1:0]       dly_buf_q [`PDS_NUM_PT];
   logic [`PDS_CNT_W-1:0]       dly_act_q [`PDS_NUM_PT];
   logic [`PDS_NUM_PT-1:0]      hit;
   logic [`PDS_NUM_PT-1:0]      fired_q;
   logic [`PDS_NUM_PT-1:0]      fire_q;
   logic [`PDS_NUM_PT-1:0]      lock_q;
   logic                        ld_arm_q;
   logic                        load_now;
   logic                        err_q;
   logic                        irq_q;

   pds_router u_router (
      .clk_sys    (clk_sys),
      .nrst       (nrst),
      .trig_src   (trig_src),
      .route_ctrl (route_ctrl),
      .routed_q   (routed_q)
   );

   assign routed_trig = routed_q;

   // Input trigger: one of the four routed slots of the delay target
   assign trig_in  = routed_q[`PDS_TGT_DELAY][scheduler_control.trig_sel]; // see R15
   assign trig_evt = trig_in & ~trig_d_q & scheduler_control.en;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         trig_d_q <= 1'b0;
      end else begin
         trig_d_q <= trig_in;
      end
   end

   // Prescaler divides by a power of two
   assign presc_lim = `PDS_PRE_CNT_W'((`PDS_PRE_ONE << scheduler_control.prescale) - `PDS_PRE_ONE); // see R15
   assign tick      = (pre_cnt_q == presc_lim);
   assign mod_hit   = running_q & tick & (cnt_q == mod_act_q);

   always_ff @(posedge clk_sys) begin
      if (!nrst || !scheduler_control.en) begin
         running_q <= 1'b0;
         cnt_q     <= `PDS_CNT_RST;
         pre_cnt_q <= '0;
      end else if (trig_evt) begin
         running_q <= 1'b1; // see R6
         cnt_q     <= `PDS_CNT_RST;
         pre_cnt_q <= '0;
      end else if (running_q) begin
         if (tick) begin
            pre_cnt_q <= '0;
            if (cnt_q == mod_act_q) begin
               cnt_q     <= `PDS_CNT_RST;
               running_q <= scheduler_control.cont;
            end else begin
               cnt_q <= cnt_q + `PDS_CNT_ONE; // see R9
            end
         end else begin
            pre_cnt_q <= pre_cnt_q + `PDS_PRE_CNT_W'(1);
         end
      end
   end

   // Load-ok stays armed until the chosen load moment; a new request wins
   always_comb begin
      unique case (scheduler_control.ld_mode)
         `PDS_LD_IMM:    load_now = ld_arm_q;
         `PDS_LD_MOD:    load_now = ld_arm_q & mod_hit;
         `PDS_LD_TRIG:   load_now = ld_arm_q & trig_evt; // see R14
         `PDS_LD_EITHER: load_now = ld_arm_q & (trig_evt | mod_hit);
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ld_arm_q <= 1'b0;
      end else begin
         ld_arm_q <= load_ok | (ld_arm_q & ~load_now); // see R14
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         mod_buf_q <= `PDS_MOD_RST;
         mod_act_q <= `PDS_MOD_RST;
      end else begin
         if (mod_we) begin
            mod_buf_q <= mod_wdata;
         end
         if (load_now) begin
            mod_act_q <= mod_buf_q;
         end
      end
   end

   genvar i;
   generate
      for (i = 0; i < `PDS_NUM_PT; i++) begin : g_pt
         // Back-to-back chains a pre-trigger on the previous conversion
         if (i == 0) begin : g_first
            assign hit[i] = running_q & pt_cfg[i].en & ~fired_q[i] & (cnt_q == dly_act_q[i]); // see R18
         end else begin : g_next
            assign hit[i] = running_q & pt_cfg[i].en & ~fired_q[i] &
                            (pt_cfg[i].back_to_back ? (lock_q[i-1] & conversion_complete[i-1])
                                                    : (cnt_q == dly_act_q[i])); // see R7
         end

         always_ff @(posedge clk_sys) begin
            if (!nrst) begin
               dly_buf_q[i] <= `PDS_DLY_RST;
               dly_act_q[i] <= `PDS_DLY_RST;
            end else begin
               if (dly_we[i]) begin
                  dly_buf_q[i] <= dly_wdata; // see R8
               end
               if (load_now) begin
                  dly_act_q[i] <= dly_buf_q[i]; // see R14
               end
            end
         end

         // Once per period; a wrap in continuous mode re-arms too
         always_ff @(posedge clk_sys) begin
            if (!nrst) begin
               fired_q[i] <= 1'b0;
               fire_q[i]  <= 1'b0;
            end else begin
               fire_q[i] <= hit[i]; // see R18
               if (trig_evt || mod_hit) begin
                  fired_q[i] <= 1'b0;
               end else if (hit[i]) begin
                  fired_q[i] <= 1'b1;
               end
            end
         end

         // Set wins over the conversion-complete release
         always_ff @(posedge clk_sys) begin
            if (!nrst) begin
               lock_q[i] <= 1'b0;
            end else begin
               lock_q[i] <= hit[i] | (lock_q[i] & ~conversion_complete[i]); // see R17
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         err_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         err_q <= (|(hit & lock_q)) | (err_q & ~err_clr); // see R19
         irq_q <= err_q & scheduler_control.err_irq_en; // see R13
      end
   end

   assign pretrig      = fire_q;
   assign pretrig_lock = lock_q;
   assign seq_err      = err_q;
   assign seq_err_irq  = irq_q;
   assign load_pending = ld_arm_q;
   assign running      = running_q;
   assign count        = cnt_q;

   AST_PULSE_ONE: assert property (@(posedge clk_sys) disable iff (!nrst) // see R18
      fire_q[0] && !trig_evt && !mod_hit |=> !fire_q[0]) else $error("pretrigger 0 longer than one clock");
   AST_FIRE_LOCKS: assert property (@(posedge clk_sys) disable iff (!nrst) // see R17
      hit[1] |=> lock_q[1] && fire_q[1]) else $error("pretrigger 1 fired without lock");
   AST_LOCK_RELEASE: assert property (@(posedge clk_sys) disable iff (!nrst) // see R17
      lock_q[0] && conversion_complete[0] && !hit[0] |=> !lock_q[0]) else $error("lock not released");
   AST_LOCK_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst) // see R17
      lock_q[0] && !conversion_complete[0] |=> lock_q[0]) else $error("lock dropped early");
   AST_SEQ_ERR: assert property (@(posedge clk_sys) disable iff (!nrst) // see R19
      (hit[0] && lock_q[0]) || (hit[1] && lock_q[1]) |=> err_q) else $error("sequence error missed");
   AST_ERR_STICKY: assert property (@(posedge clk_sys) disable iff (!nrst) // see R13
      err_q && !err_clr |=> err_q) else $error("error flag lost");
   AST_IRQ: assert property (@(posedge clk_sys) disable iff (!nrst) // see R13
      $rose(err_q) && scheduler_control.err_irq_en |=> irq_q) else $error("irq not raised");
   AST_TRIG_LOAD: assert property (@(posedge clk_sys) disable iff (!nrst) // see R14
      ld_arm_q && trig_evt && scheduler_control.ld_mode == `PDS_LD_TRIG && !load_ok
      |=> !ld_arm_q && dly_act_q[0] == $past(dly_buf_q[0])) else $error("trigger load failed");
   AST_NO_EARLY_LOAD: assert property (@(posedge clk_sys) disable iff (!nrst) // see R14
      !load_now |=> $stable(dly_act_q[1])) else $error("active delay changed without load");
   AST_RESTART: assert property (@(posedge clk_sys) disable iff (!nrst) // see R6
      trig_evt |=> running_q && cnt_q == `PDS_CNT_RST ##1 running_q) else $error("counter not restarted");
   AST_MATCH: assert property (@(posedge clk_sys) disable iff (!nrst) // see R7
      running_q && pt_cfg[0].en && !fired_q[0] && cnt_q == dly_act_q[0] |=> fire_q[0]) else $error("missed match");
endmodule
`default_nettype wire

// File: pds_far_end.sv
// Far-side model: timer trigger source and two converters
`timescale 1ns/1ps
`default_nettype none

module pds_far_end #(
   parameter int SRC = 5
) (
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        fire,
   input  wire logic [7:0]  lat,
   input  wire logic [1:0]  pretrig,
   output logic [63:0]      trig_src,
   output logic [1:0]       conversion_complete
);
   logic [7:0] wait_q [2];
   logic       noise_q;

   // Neighbour source toggles so a wrong selection shows up at once
   always_ff @(posedge clk_sys) begin
      noise_q <= nrst ? ~noise_q : 1'b0;
   end

   always_comb begin
      trig_src = '0;
      trig_src[SRC] = fire;
      trig_src[SRC+1] = noise_q;
   end

   for (genvar i = 0; i < 2; i++) begin : g_adc
      // Conversion takes lat cycles, then flags completion once
      always_ff @(posedge clk_sys) begin
         if (!nrst || pretrig[i]) begin
            wait_q[i] <= pretrig[i] ? lat : 8'h00;
         end else if (wait_q[i] != 8'h00) begin
            wait_q[i] <= wait_q[i] - 8'h01;
         end
      end
      assign conversion_complete[i] = (wait_q[i] == 8'h01);
   end
endmodule

`default_nettype wire

// File: tb_pds_scheduler.sv
// Self-checking testbench for the pre-trigger delay scheduler
`timescale 1ns/1ps
`default_nettype none
`include "pds_params.svh"

module tb_pds_scheduler;
   import pds_pkg::*;
   logic                 clk_sys, nrst, fire, load_ok, mod_we, err_clr;
   logic                 seq_err, seq_irq, load_pending, running;
   logic [7:0]           lat;
   logic [1:0]           dly_we, conv_done, pretrig, lock;
   logic [15:0]          wdata, count;
   logic [63:0]          trig_src;
   pds_route_t [7:0]     route_ctrl;
   pds_pt_cfg_t [1:0]    pt_cfg;
   pds_ctrl_t            ctrl;
   logic [7:0][3:0]      routed;
   int                   n_errors, n_tests;

   pds_scheduler dut_u (.clk_sys(clk_sys), .nrst(nrst), .trig_src(trig_src), .route_ctrl(route_ctrl),
      .scheduler_control(ctrl), .pt_cfg(pt_cfg), .load_ok(load_ok), .mod_we(mod_we), .mod_wdata(wdata),
      .dly_we(dly_we), .dly_wdata(wdata), .conversion_complete(conv_done), .err_clr(err_clr),
      .routed_trig(routed), .pretrig(pretrig), .pretrig_lock(lock), .seq_err(seq_err),
      .seq_err_irq(seq_irq), .load_pending(load_pending), .running(running), .count(count));
   pds_far_end #(.SRC(5)) adc_u (.clk_sys(clk_sys), .nrst(nrst), .fire(fire), .lat(lat),
      .pretrig(pretrig), .trig_src(trig_src), .conversion_complete(conv_done));

   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic put(input logic m, input logic [1:0] d, input logic [15:0] v, input logic ld);
      mod_we = m;
      dly_we = d;
      wdata = v;
      load_ok = ld;
      tick();
      {mod_we, dly_we, load_ok} = '0;
      tick();
   endtask

   // Waits for the period to end with both channels released
   task automatic wait_idle;
      int n;
      for (n = 0; n < 2200 && (running !== 1'b0 || lock !== 2'b00); n++) tick();
      chk(n < 2200, 1);
      if (n >= 2200) complete_run();
   endtask

   task automatic period(input int d0, input int d1);
      int at0, at1, pulses, n;
      at0 = -1;
      at1 = -1;
      pulses = 0;
      fire = 1'b1;
      tick();
      fire = 1'b0;
      for (n = 2; n < 2200 && !(n > 4 && running !== 1'b1); n++) begin
         tick();
         pulses += $countones(pretrig);
         if (pretrig[0] === 1'b1 && at0 < 0) at0 = n;
         if (pretrig[1] === 1'b1 && at1 < 0) at1 = n;
         if (pretrig !== 2'b00) chk(lock & pretrig, pretrig);
      end
      chk(n < 2200, 1);
      chk(at0, d0 + 3);
      chk(at1, d1 + 3);
      chk(pulses, 2);
      wait_idle();
      chk(lock, 2'b00);
   endtask

   task automatic t_route;
      logic prev;
      fire = 1'b1;
      tick();
      chk({routed[2][0], routed[1][0], routed[0][0]}, 3'b111);
      chk(routed[7], 4'h0);
      prev = routed[3][1];
      tick();
      fire = 1'b0;
      chk(routed[3][1], !prev);
      tick(3);
      chk({running, count}, 17'h0);
   endtask

   task automatic t_seq_err;
      lat = 8'hc8;
      fire = 1'b1;
      tick();
      fire = 1'b0;
      tick(19);
      fire = 1'b1;
      tick();
      fire = 1'b0;
      tick(5);
      chk({seq_err, seq_irq}, 2'b11);
      err_clr = 1'b1;
      tick();
      err_clr = 1'b0;
      tick(2);
      chk({seq_err, seq_irq}, 2'b00);
      lat = 8'h08;
      wait_idle();
   endtask

   // Pre-trigger 1 chained on converter 0 done: latency plus one
   task automatic t_b2b;
      pt_cfg[1].back_to_back = 1'b1;
      period(0, 9);
      pt_cfg[1].back_to_back = 1'b0;
   endtask

   // Continuous run at half rate; a buffered delay lands at the wrap
   task automatic t_cont;
      int n;
      ctrl.cont = 1'b1;
      ctrl.prescale = 3'h1;
      put(1'b1, 2'b00, 16'd9, 1'b0);
      put(1'b0, 2'b10, 16'd4, 1'b1);
      fire = 1'b1;
      tick();
      fire = 1'b0;
      for (n = 2; n <= 60; n++) begin
         tick();
         chk(pretrig, {n == 11 || n == 35 || n == 55, n == 3 || n == 23 || n == 43});
         if (n == 12) begin
            ctrl.ld_mode = `PDS_LD_MOD;
            dly_we = 2'b10;
            wdata = 16'd6;
            load_ok = 1'b1;
         end
         if (n == 13) {dly_we, load_ok} = '0;
      end
      chk({running, load_pending, seq_err}, 3'b100);
      ctrl.en = 1'b0;
      tick();
      chk(running, 1'b0);
      wait_idle();
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   initial begin
      {n_errors, n_tests} = '0;
      {nrst, fire, load_ok, mod_we, err_clr, dly_we, wdata} = '0;
      lat = 8'h08;
      route_ctrl = '0;
      pt_cfg = {2{2'b10}};
      route_ctrl[0][0] = 8'h05;
      route_ctrl[1][0] = 8'h05;
      route_ctrl[2][0] = 8'h05;
      route_ctrl[3][1] = 8'h06;
      ctrl = '{en:1'b0, cont:1'b0, ld_mode:`PDS_LD_IMM, prescale:3'h0, trig_sel:2'h0, err_irq_en:1'b1};
      tick(10);
      nrst = 1'b1;
      t_route();
      ctrl.en = 1'b1;
      put(1'b1, 2'b00, 16'd2000, 1'b0);
      put(1'b0, 2'b01, 16'd0, 1'b0);
      put(1'b0, 2'b10, 16'd180, 1'b0);
      put(1'b0, 2'b00, 16'd0, 1'b1);
      tick(2);
      chk(load_pending, 1'b0);
      period(0, 180);
      ctrl.ld_mode = `PDS_LD_TRIG;
      put(1'b0, 2'b10, 16'd1800, 1'b0);
      period(0, 180);
      put(1'b0, 2'b00, 16'd0, 1'b1);
      tick(3);
      chk(load_pending, 1'b1);
      period(0, 1800);
      chk(load_pending, 1'b0);
      t_seq_err();
      t_b2b();
      t_cont();
      complete_run();
   end
endmodule

`default_nettype wire
